// >>> dpi_consts.vh
/*
 * Constants for the dual port interleave clocking block: APB register map,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef DPI_CONSTS_VH
`define DPI_CONSTS_VH

`define DPI_DATA_W        10
`define DPI_MIDSCALE      10'h200
`define DPI_FIFO_DEPTH    8
`define DPI_FIFO_AW       3

`define DPI_ADDR_CTRL     12'h000
`define DPI_ADDR_STATUS   12'h004
`define DPI_ADDR_DATA     12'h008
`define DPI_ADDR_DROPS    12'h00c

`define DPI_CTRL_CAPT     0
`define DPI_CTRL_RST      1'b0
`define DPI_ST_LOCK       0
`define DPI_ST_MULT       1
`define DPI_ST_INTLV      2
`define DPI_ST_OVF        3
`define DPI_ST_EMPTY      4
`define DPI_ST_SEL_LO     8
`define DPI_ST_CNT_LO     16

`define DPI_MODE_INTLV    2'h0
`define DPI_CNT_W         8
`define DPI_CNT_MAX       8'hff
`define DPI_LOCK_BASE     4'h4
`define DPI_LOCK_W        8

`endif

// >>> dpi_interleave.v
/*
 * Dual input port interleave and clocking logic of a two-port converter,
 * with a capture FIFO read over APB, and the FIFO module it uses.
 * Assumes ref_clk is far faster than the applied converter clock pin, and
 * that data pins are stable around the applied clock's rising edge.
 */
//
// Overview of operation
// [R01] Interleaving alternates port one and port two into the core at twice the load rate.
// [R02] For pseudo zero stuffing the source holds port two at midscale and sends data on port one.
// [R03] The multiplier enable input picks multiplier path or full-rate clock path.
// [R04] With the multiplier on, the source clocks at half the core update rate.
// [R05] With the multiplier on, the device makes the doubled update timing from the input clock.
// [R06] With the multiplier on, the lock output goes high once the multiplier has locked.
// [R07] With the multiplier on, the two select inputs set the multiplier ratio; here they set only the lock threshold and the ratio stays two.
// [R08] With the multiplier off, the source clocks at the full core update rate.
// [R09] With the multiplier off, the applied clock is divided by two for port loading.
// [R10] With the multiplier off, the lock output carries the per-port rate sync clock.
// [R11] With the multiplier off, the select inputs pick interleaved or non-interleaved mode.
// [R12] The held midscale code is the ten bit value with only the top bit set.
`timescale 1ns/1ps
`default_nettype none
`include "dpi_consts.vh"

module dpi_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             ref_clk,   // System clock
	input  wire             reset_n,   // Synchronous reset, active low
	input  wire             inValid,   // Write request
	output wire             inReady,   // Space available
	input  wire [WIDTH-1:0] inData,    // Write word
	output wire             outValid,  // Word available
	input  wire             outReady,  // Read acknowledge
	output wire [WIDTH-1:0] outData,   // Head word
	output wire [AW:0]      level      // Words held
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_q;
	reg [AW-1:0]    rdPtr_q;
	reg [AW:0]      count_q;
	wire            doPush;
	wire            doPop;

	assign inReady  = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData  = mem[rdPtr_q];
	assign level    = count_q;
	assign doPush   = inValid & inReady;
	assign doPop    = outValid & outReady;

	always @(posedge ref_clk) begin
		if (doPush) begin
			mem[wrPtr_q] <= inData;
		end
	end

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (doPush) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (doPop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (doPush && !doPop) begin
				count_q <= count_q + 1'b1;
			end else if (doPop && !doPush) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // dpi_fifo

module dpi_interleave (
	input  wire        ref_clk,                  // 200 MHz system clock
	input  wire        reset_n,                  // Synchronous reset, active low
	input  wire        dacClkIn,                 // Applied converter clock pin
	input  wire        multiplier_enable_select, // High selects multiplier path
	input  wire        ratio_select_bit0,        // Ratio or mode select, bit 0
	input  wire        ratio_select_bit1,        // Ratio or mode select, bit 1
	input  wire [9:0]  portOneData,              // First input port
	input  wire [9:0]  portTwoData,              // Second input port
	output reg         lock_or_sync_clock_out,   // Lock flag or 1x sync clock
	output reg  [9:0]  coreSample,               // Word presented to the core
	output reg         coreUpdate,               // One-cycle core update pulse
	input  wire        psel,                     // APB select
	input  wire        penable,                  // APB enable
	input  wire        pwrite,                   // APB direction
	input  wire [11:0] paddr,                    // APB byte address
	input  wire [31:0] pwdata,                   // APB write data
	output reg  [31:0] prdata,                   // APB read data
	output reg         pready,                   // APB ready
	output reg         pslverr                   // APB error, unmapped address
);
	reg  [2:0]               clkSync_q;
	reg  [1:0]               multSync_q;
	reg  [1:0]               sel0Sync_q;
	reg  [1:0]               sel1Sync_q;
	reg  [9:0]               p1Meta_q;
	reg  [9:0]               p1Sync_q;
	reg  [9:0]               p2Meta_q;
	reg  [9:0]               p2Sync_q;
	reg  [9:0]               p1Latch_q;
	reg  [9:0]               p2Latch_q;
	reg                      divPhase_q;
	reg  [`DPI_CNT_W-1:0]    periodCnt_q;
	reg  [`DPI_CNT_W-1:0]    lastPeriod_q;
	reg  [`DPI_CNT_W-1:0]    phaseCnt_q;
	reg                      midPending_q;
	reg  [`DPI_LOCK_W-1:0]   stableCnt_q;
	reg                      locked_q;
	reg                      captEn_q;
	reg                      ovf_q;
	reg  [31:0]              drops_q;
	reg                      multPrev_q;
	wire                     clkRise;
	wire                     multOn;
	wire [1:0]               selBits;
	wire                     intlv;
	wire [`DPI_LOCK_W-1:0]   lockNeed;
	wire                     fifoReady;
	wire                     fifoValid;
	wire [9:0]               fifoHead;
	wire [`DPI_FIFO_AW:0]    fifoLevel;
	wire                     apbDone;
	wire                     popReq;
	reg                      updNow;
	reg  [9:0]               updWord;
	reg  [31:0]              rdWord;
	reg                      rdHit;

	function [`DPI_CNT_W-1:0] absDiff;
		input [`DPI_CNT_W-1:0] a;
		input [`DPI_CNT_W-1:0] b;
		begin
			absDiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	assign clkRise  = clkSync_q[1] & ~clkSync_q[2];
	assign multOn   = multSync_q[1];
	assign selBits  = {sel1Sync_q[1], sel0Sync_q[1]};
	assign intlv    = (selBits == `DPI_MODE_INTLV);
	assign lockNeed = {{(`DPI_LOCK_W-4){1'b0}}, `DPI_LOCK_BASE} << selBits;
	assign apbDone  = psel & penable & pready;
	assign popReq   = apbDone & ~pwrite & (paddr == `DPI_ADDR_DATA);

	// Pin inputs through two flops
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			clkSync_q  <= 3'h0;
			multSync_q <= 2'h0;
			sel0Sync_q <= 2'h0;
			sel1Sync_q <= 2'h0;
			p1Meta_q   <= `DPI_MIDSCALE;
			p1Sync_q   <= `DPI_MIDSCALE;
			p2Meta_q   <= `DPI_MIDSCALE;
			p2Sync_q   <= `DPI_MIDSCALE;
		end else begin
			clkSync_q  <= {clkSync_q[1:0], dacClkIn};
			multSync_q <= {multSync_q[0], multiplier_enable_select};
			sel0Sync_q <= {sel0Sync_q[0], ratio_select_bit0};
			sel1Sync_q <= {sel1Sync_q[0], ratio_select_bit1};
			p1Meta_q   <= portOneData;
			p1Sync_q   <= p1Meta_q;
			p2Meta_q   <= portTwoData;
			p2Sync_q   <= p2Meta_q;
		end
	end

	// Update scheduling per clock mode
	always @* begin
		updNow  = 1'b0;
		updWord = p1Latch_q;
		if (multOn) begin
			// [R05] Doubled update timing
			if (clkRise) begin
				updNow  = locked_q;
				updWord = p1Sync_q;
			end else if (midPending_q && phaseCnt_q == (lastPeriod_q >> 1)) begin
				// [R01] Second half takes port two
				updNow  = locked_q;
				updWord = p2Latch_q;
			end
		end else if (clkRise) begin
			updNow = 1'b1;
			// [R11] Mode from select bits
			if (intlv) begin
				updWord = divPhase_q ? p2Latch_q : p1Sync_q;
			end else begin
				updWord = divPhase_q ? p1Latch_q : p1Sync_q;
			end
		end
	end

	// [R03] Clock path selection
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			divPhase_q   <= 1'b0;
			periodCnt_q  <= {`DPI_CNT_W{1'b0}};
			lastPeriod_q <= {`DPI_CNT_W{1'b0}};
			phaseCnt_q   <= {`DPI_CNT_W{1'b0}};
			midPending_q <= 1'b0;
			stableCnt_q  <= {`DPI_LOCK_W{1'b0}};
			locked_q     <= 1'b0;
			p1Latch_q    <= `DPI_MIDSCALE;
			p2Latch_q    <= `DPI_MIDSCALE;
			multPrev_q   <= 1'b0;
		end else begin
			multPrev_q <= multOn;
			if (multOn != multPrev_q) begin
				// Mode change restarts lock and divider
				divPhase_q  <= 1'b0;
				stableCnt_q <= {`DPI_LOCK_W{1'b0}};
				locked_q    <= 1'b0;
			end else if (multOn) begin
				divPhase_q <= 1'b0;
				if (periodCnt_q != `DPI_CNT_MAX) begin
					periodCnt_q <= periodCnt_q + 1'b1;
				end
				if (phaseCnt_q != `DPI_CNT_MAX) begin
					phaseCnt_q <= phaseCnt_q + 1'b1;
				end
				if (clkRise) begin
					p1Latch_q    <= p1Sync_q;
					p2Latch_q    <= p2Sync_q;
					periodCnt_q  <= {`DPI_CNT_W{1'b0}};
					lastPeriod_q <= periodCnt_q;
					phaseCnt_q   <= {`DPI_CNT_W{1'b0}};
					midPending_q <= 1'b1;
					// [R07] Ratio sets lock threshold
					if (absDiff(periodCnt_q, lastPeriod_q) > {{(`DPI_CNT_W-1){1'b0}}, 1'b1}
							|| periodCnt_q == `DPI_CNT_MAX) begin
						stableCnt_q <= {`DPI_LOCK_W{1'b0}};
						locked_q    <= 1'b0;
					end else if (stableCnt_q >= lockNeed) begin
						// [R06] Lock achieved
						locked_q <= 1'b1;
					end else begin
						stableCnt_q <= stableCnt_q + 1'b1;
					end
				end else if (midPending_q && phaseCnt_q == (lastPeriod_q >> 1)) begin
					midPending_q <= 1'b0;
				end
			end else if (clkRise) begin
				// [R09] Divide by two for port loads
				divPhase_q <= ~divPhase_q;
				if (!divPhase_q) begin
					p1Latch_q <= p1Sync_q;
					p2Latch_q <= p2Sync_q;
				end
			end
		end
	end

	// Core output and lock pin
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			coreSample             <= `DPI_MIDSCALE;
			coreUpdate             <= 1'b0;
			lock_or_sync_clock_out <= 1'b0;
		end else begin
			coreUpdate <= updNow;
			if (updNow) begin
				coreSample <= updWord;
			end
			// [R10] Sync clock or lock flag
			lock_or_sync_clock_out <= multOn ? locked_q : (divPhase_q ^ clkRise);
		end
	end

	dpi_fifo #(
		.WIDTH (`DPI_DATA_W),
		.DEPTH (`DPI_FIFO_DEPTH),
		.AW    (`DPI_FIFO_AW)
	) u_fifo (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.inValid  (updNow & captEn_q),
		.inReady  (fifoReady),
		.inData   (updWord),
		.outValid (fifoValid),
		.outReady (popReq),
		.outData  (fifoHead),
		.level    (fifoLevel)
	);

	// Register read mux
	always @* begin
		rdHit  = 1'b1;
		rdWord = 32'h0000_0000;
		case (paddr)
		`DPI_ADDR_CTRL: begin
			rdWord[`DPI_CTRL_CAPT] = captEn_q;
		end
		`DPI_ADDR_STATUS: begin
			rdWord[`DPI_ST_LOCK]                    = locked_q;
			rdWord[`DPI_ST_MULT]                    = multOn;
			rdWord[`DPI_ST_INTLV]                   = intlv;
			rdWord[`DPI_ST_OVF]                     = ovf_q;
			rdWord[`DPI_ST_EMPTY]                   = ~fifoValid;
			rdWord[`DPI_ST_SEL_LO+1:`DPI_ST_SEL_LO] = selBits;
			rdWord[`DPI_ST_CNT_LO+`DPI_FIFO_AW:`DPI_ST_CNT_LO] = fifoLevel;
		end
		`DPI_ADDR_DATA: begin
			rdWord[`DPI_DATA_W-1:0] = fifoHead;
		end
		`DPI_ADDR_DROPS: begin
			rdWord = drops_q;
		end
		default: begin
			rdHit = 1'b0;
		end
		endcase
	end

	// APB slave, one wait state
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= 32'h0000_0000;
			captEn_q <= `DPI_CTRL_RST;
			ovf_q    <= 1'b0;
			drops_q  <= 32'h0000_0000;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rdHit;
			if (psel && penable && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rdWord;
			end
			if (apbDone && pwrite && paddr == `DPI_ADDR_CTRL) begin
				captEn_q <= pwdata[`DPI_CTRL_CAPT];
			end
			// Full FIFO drops the sample; set beats clear
			if (updNow && captEn_q && !fifoReady) begin
				ovf_q   <= 1'b1;
				drops_q <= drops_q + 1'b1;
			end else if (apbDone && pwrite && paddr == `DPI_ADDR_STATUS
					&& pwdata[`DPI_ST_OVF]) begin
				ovf_q <= 1'b0;
			end
		end
	end
endmodule // dpi_interleave
`default_nettype wire

// >>> dpi_interleave_test.sv
/* Bench for dpi_interleave: APB tasks, update counting per mode.
   Assumes dpi_source and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module dpi_interleave_test;
	logic        ref_clk, reset_n, run, stuffing, mes, sel0, sel1, psel, penable, pwrite, e;
	logic        prevClk;
	logic [7:0]  halfPer;
	logic [9:0]  oneVal, twoVal;
	logic [11:0] paddr;
	logic [31:0] pwdata, q;
	logic [2:0]  tab [5] = '{3'b000, 3'b100, 3'b001, 3'b010, 3'b011};
	logic [9:0]  fx [8] = '{10'h155, 10'h2aa, 10'h155, 10'h2aa, 10'h155, 10'h2aa, 10'h155, 10'h200};
	wire         dacClkIn, lockOut, coreUpdate, pready, pslverr;
	wire  [9:0]  portOneData, portTwoData, coreSample;
	wire  [31:0] prdata;
	int          errCount, nCompared, nUpd, nOne, nTwo, nRise, r, u, startRise;
	dpi_source u_dpi_source (.ref_clk(ref_clk), .run(run), .halfPer(halfPer), .stuffing(stuffing),
		.oneVal(oneVal), .twoVal(twoVal), .dacClkIn(dacClkIn), .portOneData(portOneData),
		.portTwoData(portTwoData));
	dpi_interleave u_dpi_interleave (.ref_clk(ref_clk), .reset_n(reset_n), .dacClkIn(dacClkIn),
		.multiplier_enable_select(mes), .ratio_select_bit0(sel0), .ratio_select_bit1(sel1),
		.portOneData(portOneData), .portTwoData(portTwoData), .lock_or_sync_clock_out(lockOut),
		.coreSample(coreSample), .coreUpdate(coreUpdate), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	initial ref_clk = 1'b0;
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		prevClk <= dacClkIn;
		if (dacClkIn && !prevClk)
			nRise++;
		if (coreUpdate === 1'b1) begin
			nUpd++;
			nOne += (coreSample === oneVal);
			nTwo += (coreSample === (stuffing ? 10'h200 : twoVal));
		end
	end
	task final_report;
		$display("compared %0d mismatches %0d", nCompared, errCount);
		if (errCount == 0 && nCompared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(i < 20, 1);
		if (i >= 20)
			final_report;
		@(posedge ref_clk);
	endtask
	task automatic upto(input int t);
		int k;
		for (k = 0; k < 4000 && nRise < t; k++)
			@(negedge ref_clk);
		if (nRise < t) begin
			errCount++;
			final_report;
		end
	endtask
	task automatic rises(input int n);
		nRise = 0;
		nUpd = 0;
		nOne = 0;
		nTwo = 0;
		run <= 1'b1;
		upto(n);
		@(posedge ref_clk);
		run <= 1'b0;
		repeat (30) @(posedge ref_clk);
	endtask
	initial begin
		{reset_n, run, stuffing, mes, sel0, sel1, psel, penable, pwrite, prevClk} = '0;
		{errCount, nCompared, nUpd, nOne, nTwo, nRise} = '0;
		halfPer = 8'h04;
		oneVal = 10'h155;
		twoVal = 10'h2aa;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({q[30:0], e}, 32'h0000_0001);
		apb(1'b1, 12'h000, 32'h1);
		for (r = 0; r < 5; r++) begin
			{stuffing, sel1, sel0} <= tab[r];
			@(posedge ref_clk);
			rises(6);
			chk(nUpd, 6);
			chk(nOne, r < 2 ? 3 : 6);
			chk(nTwo, r < 2 ? 3 : 0);
		end
		apb(1'b0, 12'h004, 32'h0);
		chk({q[19:16], q[4:3]}, 6'h21);
		for (r = 0; r < 8; r++) begin
			apb(1'b0, 12'h008, 32'h0);
			chk(q[9:0], fx[r]);
		end
		apb(1'b0, 12'h00c, 32'h0);
		chk(q, 32'h16);
		apb(1'b1, 12'h004, 32'h8);
		apb(1'b0, 12'h004, 32'h0);
		chk(q[4:3], 2'b10);
		apb(1'b1, 12'h000, 32'h0);
		halfPer <= 8'h0a;
		for (r = 0; r < 4; r++) begin
			{mes, sel1, sel0} <= {1'b1, r[1:0]};
			run <= 1'b1;
			startRise = nRise;
			for (u = 0; u < 4000 && lockOut !== 1'b1; u++)
				@(negedge ref_clk);
			chk(lockOut, 1);
			chk((nRise - startRise) > (4 << r), 1);
			if (u >= 4000)
				final_report;
			@(posedge ref_clk);
			apb(1'b0, 12'h004, 32'h0);
			chk(q[1:0], 2'b11);
			upto(nRise + 1);
			u = nUpd;
			upto(nRise + 8);
			chk(nUpd - u, 16);
			@(posedge ref_clk);
			run <= 1'b0;
			mes <= 1'b0;
			repeat (30) @(posedge ref_clk);
		end
		final_report;
	end
endmodule // dpi_interleave_test
`default_nettype wire

// >>> dpi_properties.sv
/* Port timing checker for dpi_interleave.
   Assumes binding into every dpi_interleave instance. */
`timescale 1ns/1ps
`default_nettype none
module dpi_properties (
	input wire logic        ref_clk,                  // Clock
	input wire logic        reset_n,                  // Reset
	input wire logic        dacClkIn,                 // Converter clock
	input wire logic        multiplier_enable_select, // Path select
	input wire logic        lock_or_sync_clock_out,   // Lock or sync
	input wire logic        coreUpdate,               // Update pulse
	input wire logic        psel,                     // APB select
	input wire logic        penable,                  // APB enable
	input wire logic [11:0] paddr,                    // APB address
	input wire logic        pready,                   // APB ready
	input wire logic        pslverr                   // APB error
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	sequence sOff;
		(!multiplier_enable_select) [*8];
	endsequence
	sequence sOn;
		multiplier_enable_select [*8];
	endsequence
	AST_UPD_PULSE: assert property (coreUpdate |=> !coreUpdate)
		else $error("update pulse too long");
	AST_SYNC_TOGGLE: assert property (
		sOff ##0 coreUpdate |-> $changed(lock_or_sync_clock_out))
		else $error("sync clock did not toggle");
	AST_SYNC_ONLY: assert property (
		sOff ##0 $changed(lock_or_sync_clock_out) |-> coreUpdate)
		else $error("sync clock moved alone");
	AST_NO_LOCK: assert property (
		sOn ##0 !lock_or_sync_clock_out |-> !coreUpdate)
		else $error("update while unlocked");
	AST_MULT_UPD: assert property (
		sOn ##0 lock_or_sync_clock_out ##1 $rose(dacClkIn) |-> ##[2:5] coreUpdate)
		else $error("no update after clock edge");
	AST_DIV_UPD: assert property (
		sOff ##1 $rose(dacClkIn) |-> ##[2:5] coreUpdate)
		else $error("no update after full rate edge");
	AST_PRDY_WAIT: assert property (psel && $rose(penable) |=> pready)
		else $error("ready not after one wait");
	AST_UNMAPPED: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr)
		else $error("unmapped access not refused");
endmodule // dpi_properties
bind dpi_interleave dpi_properties u_dpi_properties (.ref_clk(ref_clk), .reset_n(reset_n),
	.dacClkIn(dacClkIn), .multiplier_enable_select(multiplier_enable_select),
	.lock_or_sync_clock_out(lock_or_sync_clock_out), .coreUpdate(coreUpdate), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> dpi_source.sv
/* Data source model: converter clock and two sample ports.
   Assumes the bench sets values only while the clock is stopped. */
`timescale 1ns/1ps
`default_nettype none
module dpi_source (
	input  wire logic       ref_clk,     // Clock
	input  wire logic       run,         // Clock enable
	input  wire logic [7:0] halfPer,     // Half period
	input  wire logic       stuffing,    // Zero stuffing
	input  wire logic [9:0] oneVal,      // Port one word
	input  wire logic [9:0] twoVal,      // Port two word
	output var  logic       dacClkIn,    // Converter clock
	output var  logic [9:0] portOneData, // Port one
	output var  logic [9:0] portTwoData  // Port two
);
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		dacClkIn = 1'b0;
	end
	always @(posedge ref_clk) begin
		if (cnt + 8'h01 >= halfPer) begin
			cnt <= 8'h00;
			if (run || dacClkIn)
				dacClkIn <= !dacClkIn;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
	always @(posedge ref_clk) begin
		portOneData <= oneVal;
		portTwoData <= stuffing ? 10'h200 : twoVal;
	end
endmodule // dpi_source
`default_nettype wire
